/* include/fslos_map.svh */
// Purpose: Offsets, field positions, reset values, command codes and timing counts.
// Assumes: A 250 MHz pclk and an 8-bit flash command byte on the low data lanes.
// Notes: Each cycle count is derived from its time in nanoseconds, rounded up.
`ifndef FSLOS_MAP_SVH
`define FSLOS_MAP_SVH

// Register byte offsets on the APB side.
`define FSLOS_CMD_OFS 8'h00
`define FSLOS_ADDR_OFS 8'h04
`define FSLOS_WDATA_OFS 8'h08
`define FSLOS_STAT_OFS 8'h0c
`define FSLOS_PINS_OFS 8'h10

// Field positions inside the status and pin registers, and the last operation code.
`define FSLOS_ST_BUSY 8
`define FSLOS_ST_SUSP 9
`define FSLOS_ST_REFUSED 10
`define FSLOS_ST_READY 11
`define FSLOS_ST_LOCKUNK 12
`define FSLOS_PIN_RST 0
`define FSLOS_PIN_WP 1
`define FSLOS_OP_LAST 4'h9

// Status byte bits reported by the flash.
`define FSLOS_SR_READY 7
`define FSLOS_SR_CLRERR 5
`define FSLOS_SR_SUSP 2

// Reset values.
`define FSLOS_PINS_RST 2'h0
`define FSLOS_STAT_RST 8'h80

// Flash command bytes.
`define FSLOS_C_READ_ARRAY 8'hff
`define FSLOS_C_READ_STATUS 8'h70
`define FSLOS_C_CLR_STATUS 8'h50
`define FSLOS_C_WRITE 8'h40
`define FSLOS_C_SUSPEND 8'hb0
`define FSLOS_C_RESUME 8'hd0
`define FSLOS_C_LOCK_SETUP 8'h60
`define FSLOS_C_BLOCK_LOCK 8'h01
`define FSLOS_C_PERM_LOCK 8'hf1
`define FSLOS_C_CLR_LOCKS 8'hd0
`define FSLOS_C_OTP 8'hc0

// Bus timing in nanoseconds and the derived least cycle counts.
`define FSLOS_T_CLK_NS 4
`define FSLOS_T_SETUP_NS 20
`define FSLOS_T_WE_NS 50
`define FSLOS_T_ACC_NS 90
`define FSLOS_T_RECOV_NS 20
`define FSLOS_T_BUSY_NS 100
`define FSLOS_CYC(ns) 8'(((ns) + `FSLOS_T_CLK_NS - 1) / `FSLOS_T_CLK_NS)
`define FSLOS_SETUP_CYC `FSLOS_CYC(`FSLOS_T_SETUP_NS)
`define FSLOS_WE_CYC `FSLOS_CYC(`FSLOS_T_WE_NS)
`define FSLOS_ACC_CYC `FSLOS_CYC(`FSLOS_T_ACC_NS)
`define FSLOS_RECOV_CYC `FSLOS_CYC(`FSLOS_T_RECOV_NS)
`define FSLOS_BUSY_CYC `FSLOS_CYC(`FSLOS_T_BUSY_NS)

`endif

/* include/fslos_pkg.sv */
// Purpose: Types shared by the flash sequencer and its bench.
// Assumes: Nothing beyond the map header.
// Notes: Operation order defines the code written to the command register.
`default_nettype none
package fslos_pkg;
    // Operations that software can order.
    typedef enum logic [3:0] {
        OP_READ_ARRAY, OP_READ_STATUS, OP_CLR_STATUS, OP_WRITE, OP_SUSPEND,
        OP_RESUME, OP_BLOCK_LOCK, OP_PERM_LOCK, OP_CLR_LOCKS, OP_OTP
    } fslos_op_e;
    // Kind of one step of an operation.
    typedef enum logic [1:0] {K_WR, K_RD, K_WAIT, K_END} fslos_kind_e;
    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_SETUP, ST_STROBE, ST_RECOVER, ST_WAIT
    } fslos_state_e;
    // One step: its kind, a command byte, and whether user data replaces it.
    typedef struct packed {
        fslos_kind_e kind;
        logic use_data;
        logic [7:0] code;
    } fslos_step_s;
    // Flash pins driven by the controller.
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rst_n;
        logic wp_n;
        logic dq_oe_n;
        logic [18:0] addr;
        logic [15:0] dq_out;
    } fslos_pins_s;
endpackage
`default_nettype wire

/* logic/fslos_ctrl.sv */
// Purpose: APB-controlled host that drives a boot-block flash through its pins.
// Assumes: Flash inputs are synchronous to pclk; ready_busy_pin reads 1 when released.
// Notes: Suspend, resume, lock, clear-lock and one-time-area sequences are issued here.
// Functional notes
// - Host confirms suspension by status read
// - Keep reset high, protect fixed while suspended
// - Lock set is setup plus confirm write
// - Aborted clear leaves locks unknown; repeat
// - One-time program is code then data write
//
// The APB register port and the register addresses were left to the implementer.
`include "fslos_map.svh"
`default_nettype none
module fslos_ctrl import fslos_pkg::*; (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flash pins.
    output fslos_pins_s fl_out,
    input wire logic [15:0] fl_dq_in,
    input wire logic fl_ryby
);
    // Step table of each operation.
    function automatic fslos_step_s step_of(input fslos_op_e op, input logic [2:0] idx);
        fslos_step_s s;
        s = '{kind: K_END, use_data: 1'b0, code: 8'h00};
        unique case (op)
            OP_READ_ARRAY: if (idx == 3'h0) s = '{K_WR, 1'b0, `FSLOS_C_READ_ARRAY};
                else if (idx == 3'h1) s.kind = K_RD;
            OP_READ_STATUS: if (idx == 3'h0) s = '{K_WR, 1'b0, `FSLOS_C_READ_STATUS};
                else if (idx == 3'h1) s.kind = K_RD;
            OP_CLR_STATUS: if (idx == 3'h0) s = '{K_WR, 1'b0, `FSLOS_C_CLR_STATUS};
            OP_WRITE: if (idx == 3'h0) s = '{K_WR, 1'b0, `FSLOS_C_WRITE};
                else if (idx == 3'h1) s = '{K_WR, 1'b1, 8'h00};
            OP_SUSPEND: if (idx == 3'h0) s = '{K_WR, 1'b0, `FSLOS_C_SUSPEND};
                else if (idx == 3'h1) s.kind = K_WAIT;
                else if (idx == 3'h2) s = '{K_WR, 1'b0, `FSLOS_C_READ_STATUS};
                else if (idx == 3'h3) s.kind = K_RD;
            OP_RESUME: if (idx == 3'h0) s = '{K_WR, 1'b0, `FSLOS_C_RESUME};
            default: begin
                // Two-write operations that wait for ready and then read status.
                if (idx == 3'h0) begin
                    s.kind = K_WR;
                    s.code = (op == OP_OTP) ? `FSLOS_C_OTP : `FSLOS_C_LOCK_SETUP;
                end else if (idx == 3'h1) begin
                    s.kind = K_WR;
                    s.use_data = (op == OP_OTP);
                    s.code = (op == OP_BLOCK_LOCK) ? `FSLOS_C_BLOCK_LOCK :
                             (op == OP_PERM_LOCK) ? `FSLOS_C_PERM_LOCK : `FSLOS_C_CLR_LOCKS;
                end else if (idx == 3'h2) begin
                    s.kind = K_WAIT;
                end else if (idx == 3'h3) begin
                    s.kind = K_RD;
                end
            end
        endcase
        return s;
    endfunction

    // Address decode of the register map.
    function automatic logic reg_mapped(input logic [7:0] a);
        return (a == `FSLOS_CMD_OFS) || (a == `FSLOS_ADDR_OFS) || (a == `FSLOS_WDATA_OFS) ||
               (a == `FSLOS_STAT_OFS) || (a == `FSLOS_PINS_OFS);
    endfunction

    fslos_state_e state_r, state_nxt;
    fslos_op_e op_r, op_nxt;
    fslos_pins_s fl_r, fl_nxt;
    logic [2:0] idx_r, idx_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [18:0] addr_r, addr_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [7:0] sr_r, sr_nxt;
    logic susp_r, susp_nxt;
    logic refused_r, refused_nxt;
    logic lockunk_r, lockunk_nxt;
    logic [1:0] wrcnt_r, wrcnt_nxt;
    logic [7:0] lastwr_r, lastwr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic wr_go;
    logic busy;
    fslos_step_s step;
    fslos_op_e req_op;

    // Outputs straight from their flip-flops.
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign fl_out = fl_r;
    assign busy = (state_r != ST_IDLE);
    assign wr_go = psel && penable && pready_r && pwrite;
    assign step = step_of(op_r, idx_r);
    assign req_op = fslos_op_e'(pwdata[3:0]);

    // Next values of the APB slave, the registers and the pin sequencer.
    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        fl_nxt = fl_r;
        idx_nxt = idx_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        sr_nxt = sr_r;
        susp_nxt = susp_r;
        refused_nxt = refused_r;
        lockunk_nxt = lockunk_r;
        wrcnt_nxt = wrcnt_r;
        lastwr_nxt = lastwr_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        pready_nxt = 1'b0;
        // One wait state: data and error are loaded on the same edge as pready rises.
        if (psel && penable && !pready_r) begin
            pready_nxt = 1'b1;
            pslverr_nxt = !reg_mapped(paddr);
            unique case (paddr)
                `FSLOS_CMD_OFS: prdata_nxt = {27'h0, busy, op_r};
                `FSLOS_ADDR_OFS: prdata_nxt = {13'h0, addr_r};
                `FSLOS_WDATA_OFS: prdata_nxt = {16'h0, wdata_r};
                `FSLOS_STAT_OFS: prdata_nxt = {rdata_r, 3'h0, lockunk_r, fl_ryby,
                                               refused_r, susp_r, busy, sr_r};
                `FSLOS_PINS_OFS: prdata_nxt = {30'h0, fl_r.wp_n, fl_r.rst_n};
                default: prdata_nxt = 32'h0;
            endcase
        end
        // Operand registers take writes only while idle.
        if (wr_go && !busy && paddr == `FSLOS_ADDR_OFS) addr_nxt = pwdata[18:0];
        if (wr_go && !busy && paddr == `FSLOS_WDATA_OFS) wdata_nxt = pwdata[15:0];
        // A suspended device may only see read-array, read-status and resume.
        if (wr_go && paddr == `FSLOS_CMD_OFS) begin
            if (busy || pwdata[3:0] > `FSLOS_OP_LAST ||
                (susp_r && !(req_op inside {OP_READ_ARRAY, OP_READ_STATUS, OP_RESUME}))) begin
                refused_nxt = 1'b1;
            end else begin
                refused_nxt = 1'b0;
                op_nxt = req_op;
                idx_nxt = 3'h0;
                wrcnt_nxt = 2'h0;
                state_nxt = ST_FETCH;
            end
        end
        unique case (state_r)
            ST_IDLE: ;
            ST_FETCH: begin
                unique case (step.kind)
                    K_END: begin
                        state_nxt = ST_IDLE;
                        if (op_r == OP_RESUME) susp_nxt = 1'b0;
                        if (op_r == OP_CLR_LOCKS && !sr_r[`FSLOS_SR_CLRERR]) begin
                            lockunk_nxt = 1'b0;
                        end
                    end
                    K_WAIT: begin
                        cnt_nxt = `FSLOS_BUSY_CYC;
                        state_nxt = ST_WAIT;
                    end
                    default: begin
                        // Address and data stay put until the strobe has risen.
                        fl_nxt.ce_n = 1'b0;
                        fl_nxt.addr = addr_r;
                        fl_nxt.dq_oe_n = (step.kind != K_WR);
                        fl_nxt.dq_out = step.use_data ? wdata_r : {8'h00, step.code};
                        if (step.kind == K_WR) begin
                            lastwr_nxt = step.use_data ? wdata_r[7:0] : step.code;
                        end
                        cnt_nxt = `FSLOS_SETUP_CYC;
                        state_nxt = ST_SETUP;
                    end
                endcase
            end
            ST_SETUP: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r <= 8'h01) begin
                    fl_nxt.we_n = (step.kind != K_WR);
                    fl_nxt.oe_n = (step.kind == K_WR);
                    cnt_nxt = (step.kind == K_WR) ? `FSLOS_WE_CYC : `FSLOS_ACC_CYC;
                    state_nxt = ST_STROBE;
                end
            end
            ST_STROBE: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r <= 8'h01) begin
                    // Rising write strobe latches address and data in the flash.
                    fl_nxt.we_n = 1'b1;
                    fl_nxt.oe_n = 1'b1;
                    if (step.kind == K_WR) wrcnt_nxt = wrcnt_r + 2'h1;
                    if (step.kind == K_RD) begin
                        rdata_nxt = fl_dq_in;
                        if (op_r != OP_READ_ARRAY) sr_nxt = fl_dq_in[7:0];
                        if (op_r == OP_SUSPEND) begin
                            susp_nxt = fl_dq_in[`FSLOS_SR_SUSP];
                        end
                    end
                    cnt_nxt = `FSLOS_RECOV_CYC;
                    state_nxt = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r <= 8'h01) begin
                    fl_nxt.ce_n = 1'b1;
                    fl_nxt.dq_oe_n = 1'b1;
                    idx_nxt = idx_r + 3'h1;
                    state_nxt = ST_FETCH;
                end
            end
            ST_WAIT: begin
                // Give the device time to pull the pin low before trusting it.
                if (cnt_r > 8'h01) begin
                    cnt_nxt = cnt_r - 8'h01;
                end else if (fl_ryby) begin
                    idx_nxt = idx_r + 3'h1;
                    state_nxt = ST_FETCH;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        // Pin levels are frozen while a write is suspended.
        if (wr_go && paddr == `FSLOS_PINS_OFS && !susp_r) begin
            fl_nxt.wp_n = pwdata[`FSLOS_PIN_WP];
            fl_nxt.rst_n = pwdata[`FSLOS_PIN_RST];
            if (!pwdata[`FSLOS_PIN_RST] && busy) begin
                // A device reset aborts the running sequence.
                state_nxt = ST_IDLE;
                fl_nxt.ce_n = 1'b1;
                fl_nxt.oe_n = 1'b1;
                fl_nxt.we_n = 1'b1;
                fl_nxt.dq_oe_n = 1'b1;
                if (op_r == OP_CLR_LOCKS) lockunk_nxt = 1'b1;
            end
        end
    end

    // Register every next value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            op_r <= OP_READ_ARRAY;
            fl_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1,
                      rst_n: 1'(`FSLOS_PINS_RST >> `FSLOS_PIN_RST), addr: 19'h0,
                      wp_n: 1'(`FSLOS_PINS_RST >> `FSLOS_PIN_WP), dq_out: 16'h0};
            idx_r <= 3'h0;
            cnt_r <= 8'h00;
            addr_r <= 19'h0;
            wdata_r <= 16'h0;
            rdata_r <= 16'h0;
            sr_r <= `FSLOS_STAT_RST;
            susp_r <= 1'b0;
            refused_r <= 1'b0;
            lockunk_r <= 1'b0;
            wrcnt_r <= 2'h0;
            lastwr_r <= 8'h00;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            fl_r <= fl_nxt;
            idx_r <= idx_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            sr_r <= sr_nxt;
            susp_r <= susp_nxt;
            refused_r <= refused_nxt;
            lockunk_r <= lockunk_nxt;
            wrcnt_r <= wrcnt_nxt;
            lastwr_r <= lastwr_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Checks on the pin sequences.
    chk_susp_status_read: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == ST_STROBE && op_r == OP_SUSPEND && step.kind == K_RD)
        |-> lastwr_r == `FSLOS_C_READ_STATUS)
        else $error("Suspend status read not preceded by read-status command.");
    chk_susp_pins_held: assert property (@(posedge pclk) disable iff (!presetn)
        (susp_r && $past(susp_r)) |-> (fl_r.rst_n && $stable(fl_r.wp_n)))
        else $error("Reset or protect pin changed during suspension.");
    chk_lock_two_writes: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == ST_WAIT && op_r inside {OP_BLOCK_LOCK, OP_PERM_LOCK})
        |-> wrcnt_r == 2'h2)
        else $error("Lock operation waited without two bus writes.");
    chk_otp_data_write: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == ST_WAIT && op_r == OP_OTP)
        |-> (wrcnt_r == 2'h2 && lastwr_r == wdata_r[7:0]))
        else $error("One-time program waited without code and data writes.");
    chk_addr_stable_we: assert property (@(posedge pclk) disable iff (!presetn)
        (!fl_r.we_n && !$past(fl_r.we_n)) |-> ($stable(fl_r.addr) && $stable(fl_r.dq_out)))
        else $error("Address or data moved while write strobe low.");
    chk_clear_abort_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (busy && op_r == OP_CLR_LOCKS && wr_go && paddr == `FSLOS_PINS_OFS && !susp_r
         && !pwdata[`FSLOS_PIN_RST]) |=> (lockunk_r && !busy))
        else $error("Aborted clear did not flag lock bits unknown.");
    cov_suspend_ok: cover property (@(posedge pclk) disable iff (!presetn) $rose(susp_r));
    cov_resume: cover property (@(posedge pclk) disable iff (!presetn) $fell(susp_r));
    cov_otp_done: cover property (@(posedge pclk) disable iff (!presetn)
        (op_r == OP_OTP && state_r == ST_FETCH && step.kind == K_END));
    cov_refused: cover property (@(posedge pclk) disable iff (!presetn) $rose(refused_r));
endmodule // fslos_ctrl
`default_nettype wire

/* dv/fslos_flash_model.sv */
// Purpose: Behavioural flash facing the sequencer: commands, status byte and lock state.
// Assumes: Pins are sampled on pclk; a released ready/busy pin reads as 1.
// Notes: Busy times are short pclk counts; array data is an address pattern.
`default_nettype none
module fslos_flash_model import fslos_pkg::*; (
    // Clock and pins from the controller.
    input wire logic pclk,
    input wire fslos_pins_s pins,
    // Supply and one-time-area lock conditions.
    input wire logic vpp_low,
    input wire logic otp_lock,
    // Flash outputs and a flag for host misbehaviour.
    output logic [15:0] dq,
    output logic ryby,
    output logic host_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WR_CYC = 300;
    localparam int OP_CYC = 200;
    logic [7:0] sr = 8'h80;
    logic [15:0] otp = 16'hffff;
    logic [15:0] blk_lock = 16'h0000;
    logic perm = 1'b0;
    logic susp = 1'b0;
    logic stat_mode = 1'b0;
    logic prev_we = 1'b1;
    logic wp_at = 1'b0;
    int pend = 0;
    int busy = 0;
    initial host_bad = 1'b0;
    initial dq = 16'h0000;
    initial ryby = 1'b1;
    // Decodes one latched bus write; error bits are added, and only the clear-status command or a device reset removes them.
    task automatic command(input logic [15:0] d, input logic [18:0] a);
        logic [7:0] c;
        c = d[7:0];
        stat_mode = 1'b1;
        if (susp) begin
            if (c == 8'hd0) begin
                susp = 1'b0;
                sr[2] = 1'b0;
            end else if (c == 8'hff) stat_mode = 1'b0;
        end else if (pend == 1) begin
            pend = 0;
            busy = WR_CYC;
            wp_at = pins.wp_n;
        end else if (pend == 2) begin
            pend = 0;
            if (c == 8'h01 && perm) sr = sr | 8'h12;
            else if (c == 8'h01) begin
                blk_lock[a[18:15]] = 1'b1;
                busy = OP_CYC;
            end else if (c == 8'hf1) begin
                perm = 1'b1;
                busy = OP_CYC;
            end else if (c != 8'hd0) sr = sr | 8'h30;
            else if (vpp_low) sr = sr | 8'h28;
            else if (perm) sr = sr | 8'h22;
            else begin
                blk_lock = 16'h0000;
                busy = OP_CYC;
            end
        end else if (pend == 3) begin
            pend = 0;
            if (vpp_low) sr = sr | 8'h18;
            else if (otp_lock) sr = sr | 8'h12;
            else begin
                // One cell is stuck at one, so a zero aimed at it fails verify.
                otp = (otp & d) | (otp & 16'h8000);
                if ((otp & ~d) != 16'h0000) sr = sr | 8'h10;
                busy = OP_CYC;
            end
        end else begin
            case (c)
                8'hff: stat_mode = 1'b0;
                8'h50: sr = sr & 8'hc5;
                8'h40: pend = 1;
                8'h60: pend = 2;
                8'hc0: pend = 3;
                8'hb0: begin
                    if (busy > 0) susp = 1'b1;
                    else stat_mode = 1'b0;
                    sr[2] = susp;
                end
                default: ;
            endcase
        end
    endtask
    // Latches commands on the rising write strobe and runs the busy count.
    always @(posedge pclk) begin
        if (susp && (!pins.rst_n || pins.wp_n != wp_at)) host_bad <= 1'b1;
        if (!pins.rst_n) begin
            if (busy > 0) blk_lock = ~blk_lock;
            busy = 0;
            pend = 0;
            susp = 1'b0;
            stat_mode = 1'b0;
            sr = 8'h80;
        end else begin
            if (busy > 0 && !susp) busy = busy - 1;
            if (!prev_we && pins.we_n && !pins.ce_n) command(pins.dq_out, pins.addr);
        end
        sr[7] = (busy == 0) || susp;
        ryby <= sr[7];
        // A released data bus shows a changing pattern, never the last value.
        if (!pins.ce_n && !pins.oe_n) dq <= stat_mode ? {8'h00, sr} : pins.addr[15:0] ^ 16'h3c3c;
        else dq <= ~dq;
        prev_we = pins.we_n;
    end
endmodule // fslos_flash_model
`default_nettype wire

/* dv/flash_suspend_lock_otp_sequencer_bench.sv */
// Purpose: Self-checking bench for the flash sequencer against a behavioural flash.
// Assumes: Status is read back over APB after each operation ends.
// Notes: Expected status bytes come from a small reference kept in integers.
`include "fslos_map.svh"
`default_nettype none
module flash_suspend_lock_otp_sequencer_bench import fslos_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h8890;
    logic pready, pslverr, rerr, fl_ryby, host_bad, vpp_low = 1'b0, otp_lock = 1'b0;
    fslos_pins_s fl_out;
    logic [15:0] fl_dq_in, wd, e_otp = 16'hffff;
    logic [18:0] wa;
    int e_sr = 8'h80, num_errors = 0, n_compared = 0, cyc = 0;
    always #2 pclk = ~pclk;
    fslos_ctrl uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fl_out(fl_out), .fl_dq_in(fl_dq_in),
        .fl_ryby(fl_ryby));
    fslos_flash_model flash (.pclk(pclk), .pins(fl_out), .vpp_low(vpp_low),
        .otp_lock(otp_lock), .dq(fl_dq_in), .ryby(fl_ryby), .host_bad(host_bad));
    // Prints the verdict and ends the run.
    task summarize();
        if (num_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            summarize();
        end
    end
    // Compares one value and counts it.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Next value of the stimulus shift register.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // One APB transfer; the answer is taken at the edge where pready is high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Reads status until one bit reaches a level.
    task poll(input int b, input logic v);
        apb(1'b0, `FSLOS_STAT_OFS, 32'h0);
        while (rd[b] !== v) apb(1'b0, `FSLOS_STAT_OFS, 32'h0);
    endtask
    // Orders one operation and waits for it to end.
    task op(input logic [3:0] o);
        apb(1'b1, `FSLOS_CMD_OFS, {28'h0, o});
        poll(`FSLOS_ST_BUSY, 1'b0);
    endtask
    // Loads a random address and data word.
    task setup();
        seed = lfsr(seed);
        wa = seed[18:0];
        apb(1'b1, `FSLOS_ADDR_OFS, {13'h0, wa});
        seed = lfsr(seed);
        wd = seed[15:0];
        apb(1'b1, `FSLOS_WDATA_OFS, {16'h0, wd});
    endtask
    // Main sequence.
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'({fl_out.rst_n, fl_out.we_n, fl_out.ce_n}), 32'h3);
        apb(1'b0, `FSLOS_STAT_OFS, 32'h0);
        chk(32'(rd[8:0]), 32'h080);
        apb(1'b0, 8'h20, 32'h0);
        chk(32'(rerr), 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, `FSLOS_PINS_OFS, 32'h3);
        apb(1'b0, `FSLOS_PINS_OFS, 32'h0);
        chk(rd, 32'h3);
        setup();
        apb(1'b0, `FSLOS_ADDR_OFS, 32'h0);
        chk(rd, {13'h0, wa});
        op(4'h3);
        op(4'h4);
        chk(32'(rd[11:0]), 32'ha84);
        apb(1'b1, `FSLOS_CMD_OFS, 32'h6);
        apb(1'b0, `FSLOS_STAT_OFS, 32'h0);
        chk(32'(rd[10]), 32'h1);
        apb(1'b1, `FSLOS_PINS_OFS, 32'h0);
        @(negedge pclk);
        chk(32'(fl_out.rst_n), 32'h1);
        op(4'h0);
        chk(32'(rd[31:16]), 32'(wa[15:0] ^ 16'h3c3c));
        repeat (2) begin
            op(4'h5);
            chk(32'(rd[9]), 32'h0);
            op(4'h4);
            chk(32'(rd[9:0]), 32'h284);
        end
        op(4'h5);
        op(4'h1);
        chk(32'({rd[11], rd[7:0]}), 32'h000);
        poll(`FSLOS_ST_READY, 1'b1);
        op(4'h4);
        chk(32'(rd[9:0]), 32'h080);
        vpp_low <= 1'b1;
        op(4'h8);
        e_sr = e_sr | 8'h28;
        chk(32'(rd[7:0]), 32'(e_sr));
        setup();
        op(4'h9);
        e_sr = e_sr | 8'h18;
        chk(32'(rd[7:0]), 32'(e_sr));
        op(4'h2);
        op(4'h1);
        e_sr = 8'h80;
        chk(32'(rd[7:0]), 32'(e_sr));
        vpp_low <= 1'b0;
        repeat (3) begin
            setup();
            e_otp = (e_otp & wd) | (e_otp & 16'h8000);
            if ((e_otp & ~wd) != 16'h0) e_sr = e_sr | 8'h10;
            op(4'h9);
            chk(32'(rd[7:0]), 32'(e_sr));
        end
        apb(1'b1, `FSLOS_CMD_OFS, 32'h8);
        poll(`FSLOS_ST_READY, 1'b0);
        apb(1'b1, `FSLOS_PINS_OFS, 32'h0);
        poll(`FSLOS_ST_BUSY, 1'b0);
        chk(32'(rd[12]), 32'h1);
        apb(1'b1, `FSLOS_PINS_OFS, 32'h3);
        op(4'h8);
        e_sr = 8'h80;
        chk(32'({rd[12], rd[7:0]}), 32'h080);
        op(4'h6);
        chk(32'(rd[7:0]), 32'(e_sr));
        op(4'h7);
        chk(32'(rd[7:0]), 32'(e_sr));
        op(4'h6);
        e_sr = e_sr | 8'h12;
        chk(32'(rd[7:0]), 32'(e_sr));
        op(4'h8);
        e_sr = e_sr | 8'h22;
        chk(32'(rd[7:0]), 32'(e_sr));
        otp_lock <= 1'b1;
        op(4'h2);
        setup();
        op(4'h9);
        chk(32'(rd[7:0]), 32'h92);
        op(4'h2);
        op(4'h8);
        chk(32'(rd[7:0]), 32'ha2);
        chk(32'(host_bad), 32'h0);
        summarize();
    end
endmodule // flash_suspend_lock_otp_sequencer_bench
`default_nettype wire
